// file: core/bcs_map.svh
// Constant header for the branch, compare and skip unit: flag bits, timing counts, reset values.
`ifndef BCS_MAP_SVH
`define BCS_MAP_SVH
// Status register flag positions.
`define BCS_FLAG_C 3'd0
`define BCS_FLAG_Z 3'd1
`define BCS_FLAG_N 3'd2
`define BCS_FLAG_V 3'd3
`define BCS_FLAG_S 3'd4
`define BCS_FLAG_H 3'd5
// Cycle counts per operation.
`define BCS_CYC_PTR_JUMP 3'd2
`define BCS_CYC_OFS_CALL 3'd3
`define BCS_CYC_PTR_CALL 3'd3
`define BCS_CYC_DIR_CALL 3'd4
`define BCS_CYC_ONE 3'd1
// Reset values of the output registers.
`define BCS_PC_RESET 16'h0000
`define BCS_SR_RESET 8'h00
`endif

// file: core/bcs_pkg.sv
// Package with the operation codes and the request and answer carriers of the unit.
package bcs_pkg;
   typedef enum logic [4:0] {
      BCS_OP_NONE,
      BCS_OP_POINTER_JUMP,
      BCS_OP_OFFSET_CALL,
      BCS_OP_POINTER_CALL,
      BCS_OP_DIRECT_CALL,
      BCS_OP_COMPARE_SKIP_EQUAL,
      BCS_OP_COMPARE_IMMEDIATE,
      BCS_OP_SKIP_REG_BIT_CLEAR,
      BCS_OP_SKIP_REG_BIT_SET,
      BCS_OP_SKIP_IO_BIT_CLEAR,
      BCS_OP_SKIP_IO_BIT_SET,
      BCS_OP_BRANCH_FLAG_SET,
      BCS_OP_BRANCH_FLAG_CLEAR,
      BCS_OP_BRANCH_CARRY_CLEAR,
      BCS_OP_BRANCH_UNSIGNED_GE,
      BCS_OP_BRANCH_SIGNED_GE,
      BCS_OP_BRANCH_SIGNED_LT,
      BCS_OP_BRANCH_OVERFLOW_SET
   } bcs_op_t;

   // One decoded instruction as handed over by the decoder.
   typedef struct packed {
      bcs_op_t op;
      logic [15:0] pc;
      logic [15:0] target;
      logic [11:0] offset;
      logic [7:0] opnd_a;
      logic [7:0] opnd_b;
      logic [2:0] bit_sel;
      logic next_two_words;
   } bcs_req_t;

   // Result of one finished instruction.
   typedef struct packed {
      logic [15:0] pc;
      logic push;
      logic [15:0] ret_addr;
      logic [7:0] status;
   } bcs_ans_t;
endpackage : bcs_pkg

// file: core/bcs_unit.sv
// Branch, compare and skip unit: executes control-flow operations and reports the new PC.
//
// Summary of operation
// [RL1] Pointer jump loads PC from Z, two cycles, flags untouched.
// [RL2] Offset call sets PC to PC plus offset plus one, saves return, three cycles.
// [RL3] Pointer call saves return address, loads PC from Z, three cycles, flags untouched.
// [RL4] Direct call saves return address, loads absolute target, four cycles.
// [RL5] Compare-skip-equal skips next instruction when registers equal, one to three cycles.
// [RL6] Compare immediate updates Z, N, V, C, H, S from register minus constant, one cycle.
// [RL7] Skip-reg-bit-clear skips when selected register bit is zero.
// [RL8] Skip-reg-bit-set skips when selected register bit is one.
// [RL9] Skip-io-bit-clear skips when selected I/O bit is zero.
// [RL10] Skip-io-bit-set skips when selected I/O bit is one.
// [RL11] Branch-flag-set branches relative when selected status bit is one.
// [RL12] Branch-flag-clear branches relative when selected status bit is zero.
// [RL13] Branch-carry-clear branches only when carry is zero, flags unchanged.
// [RL14] Branch-unsigned-ge branches when carry is zero.
// [RL15] Branch-signed-ge branches when N xor V is zero.
// [RL16] Branch-signed-lt branches when N xor V is one.
// [RL17] Branch-overflow-set branches when overflow flag is one.
// [RL18] Branch takes one cycle untaken, two taken; skip adds a cycle per word.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_map.svh"
module bcs_unit (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_valid,
   input wire bcs_pkg::bcs_req_t i_req,
   input wire logic [15:0] i_z_pointer,
   input wire logic [7:0] i_status,
   output logic o_busy,
   output logic o_done,
   output bcs_pkg::bcs_ans_t o_ans
);
   import bcs_pkg::*;

   typedef enum logic [1:0] {BCS_ST_IDLE, BCS_ST_WAIT} bcs_state_t;

   bcs_state_t state_q;
   logic [2:0] count_q;
   bcs_ans_t ans_q;
   bcs_ans_t pend_q;
   logic done_q;

   // Relative target, sign extended offset plus one.
   wire logic [15:0] offset_ext = {{4{i_req.offset[11]}}, i_req.offset};
   wire logic [15:0] pc_next = i_req.pc + 16'h0001;
   wire logic [15:0] pc_rel = i_req.pc + offset_ext + 16'h0001; // RL2 RL12
   // Skipping a two-word instruction needs one more step and one more cycle.
   wire logic [15:0] pc_skip = i_req.next_two_words ? i_req.pc + 16'h0003 : i_req.pc + 16'h0002;
   wire logic [2:0] skip_cyc = i_req.next_two_words ? 3'd3 : 3'd2; // RL18

   // Compare immediate subtraction with borrow detection on bits 3 and 7.
   wire logic [7:0] rd = i_req.opnd_a;
   wire logic [7:0] kk = i_req.opnd_b;
   wire logic [7:0] diff = rd - kk;
   wire logic cmp_h = (~rd[3] & kk[3]) | (kk[3] & diff[3]) | (diff[3] & ~rd[3]);
   wire logic cmp_c = (~rd[7] & kk[7]) | (kk[7] & diff[7]) | (diff[7] & ~rd[7]);
   wire logic cmp_v = (rd[7] & ~kk[7] & ~diff[7]) | (~rd[7] & kk[7] & diff[7]);
   wire logic cmp_n = diff[7];
   wire logic cmp_z = (diff == 8'h00);
   wire logic [7:0] cmp_status = {i_status[7:6], cmp_h, cmp_n ^ cmp_v, cmp_v, cmp_n,
      cmp_z, cmp_c}; // RL6

   // Flag tests.
   wire logic sel_bit = i_req.opnd_a[i_req.bit_sel];
   wire logic sr_bit = i_status[i_req.bit_sel];
   wire logic f_c = i_status[`BCS_FLAG_C];
   wire logic f_n = i_status[`BCS_FLAG_N];
   wire logic f_v = i_status[`BCS_FLAG_V];

   // Decode of one request: outcome, cycle count and stack push.
   logic cond;
   logic [2:0] cycles;
   bcs_ans_t res;
   always_comb begin
      cond = 1'b0;
      res.pc = pc_next;
      res.push = 1'b0;
      res.ret_addr = pc_next;
      res.status = i_status;
      cycles = `BCS_CYC_ONE;
      case (i_req.op)
         BCS_OP_POINTER_JUMP: begin
            res.pc = i_z_pointer; // RL1
            cycles = `BCS_CYC_PTR_JUMP; // RL1
         end
         BCS_OP_OFFSET_CALL: begin
            res.pc = pc_rel; // RL2
            res.push = 1'b1; // RL2
            cycles = `BCS_CYC_OFS_CALL; // RL2
         end
         BCS_OP_POINTER_CALL: begin
            res.pc = i_z_pointer; // RL3
            res.push = 1'b1; // RL3
            cycles = `BCS_CYC_PTR_CALL; // RL3
         end
         BCS_OP_DIRECT_CALL: begin
            // A direct call is two words long, so it returns past the address word.
            res.pc = i_req.target; // RL4
            res.push = 1'b1; // RL4
            res.ret_addr = i_req.pc + 16'h0002;
            cycles = `BCS_CYC_DIR_CALL; // RL4
         end
         BCS_OP_COMPARE_IMMEDIATE: begin
            res.status = cmp_status; // RL6
         end
         BCS_OP_COMPARE_SKIP_EQUAL: cond = (i_req.opnd_a == i_req.opnd_b); // RL5
         BCS_OP_SKIP_REG_BIT_CLEAR: cond = ~sel_bit; // RL7
         BCS_OP_SKIP_REG_BIT_SET: cond = sel_bit; // RL8
         BCS_OP_SKIP_IO_BIT_CLEAR: cond = ~sel_bit; // RL9
         BCS_OP_SKIP_IO_BIT_SET: cond = sel_bit; // RL10
         BCS_OP_BRANCH_FLAG_SET: cond = sr_bit; // RL11
         BCS_OP_BRANCH_FLAG_CLEAR: cond = ~sr_bit; // RL12
         BCS_OP_BRANCH_CARRY_CLEAR: cond = ~f_c; // RL13
         BCS_OP_BRANCH_UNSIGNED_GE: cond = ~f_c; // RL14
         BCS_OP_BRANCH_SIGNED_GE: cond = ~(f_n ^ f_v); // RL15
         BCS_OP_BRANCH_SIGNED_LT: cond = f_n ^ f_v; // RL16
         BCS_OP_BRANCH_OVERFLOW_SET: cond = f_v; // RL17
         default: cond = 1'b0;
      endcase
      // Skips and branches differ only in their taken target and cost.
      if (cond) begin
         if (i_req.op inside {BCS_OP_COMPARE_SKIP_EQUAL, BCS_OP_SKIP_REG_BIT_CLEAR,
               BCS_OP_SKIP_REG_BIT_SET, BCS_OP_SKIP_IO_BIT_CLEAR, BCS_OP_SKIP_IO_BIT_SET}) begin
            res.pc = pc_skip; // RL5 RL7 RL8 RL9 RL10
            cycles = skip_cyc; // RL18
         end else begin
            res.pc = pc_rel; // RL11 RL13 RL15 RL16 RL17
            cycles = 3'd2; // RL18
         end
      end
   end

   wire logic take = i_valid && (state_q == BCS_ST_IDLE) && (i_req.op != BCS_OP_NONE);

   // Sequencer: the result appears with o_done on the last cycle of the operation.
   // Holding the answer until then keeps the fetch side from racing ahead of the count.
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q <= BCS_ST_IDLE;
         count_q <= 3'd0;
         pend_q <= '0;
      end else begin
         case (state_q)
            BCS_ST_IDLE: begin
               if (take && cycles != `BCS_CYC_ONE) begin
                  state_q <= BCS_ST_WAIT;
                  count_q <= cycles - 3'd2;
                  pend_q <= res;
               end
            end
            BCS_ST_WAIT: begin
               if (count_q == 3'd0) begin
                  state_q <= BCS_ST_IDLE;
               end else begin
                  count_q <= count_q - 3'd1;
               end
            end
            default: state_q <= BCS_ST_IDLE;
         endcase
      end
   end

   // Output registers.
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         done_q <= 1'b0;
         ans_q <= '{pc: `BCS_PC_RESET, push: 1'b0, ret_addr: `BCS_PC_RESET,
            status: `BCS_SR_RESET};
      end else begin
         done_q <= (take && cycles == `BCS_CYC_ONE) ||
            (state_q == BCS_ST_WAIT && count_q == 3'd0);
         if (take && cycles == `BCS_CYC_ONE) begin
            ans_q <= res;
         end else if (state_q == BCS_ST_WAIT && count_q == 3'd0) begin
            ans_q <= pend_q;
         end
      end
   end

   // Busy covers every cycle of a multi-cycle operation after the taking edge except the last, which carries o_done.
   logic busy_q;
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= (take && cycles != `BCS_CYC_ONE) ||
            (state_q == BCS_ST_WAIT && count_q != 3'd0);
      end
   end

   assign o_busy = busy_q;
   assign o_done = done_q;
   assign o_ans = ans_q;
endmodule : bcs_unit
`default_nettype wire

// file: tb/bcs_unit_sva.sv
// Checker for the branch, compare and skip unit.
`timescale 1ns/1ps
`default_nettype none
module bcs_unit_sva (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_valid,
   input wire bcs_pkg::bcs_req_t i_req,
   input wire logic [15:0] i_z_pointer,
   input wire logic [7:0] i_status,
   input wire logic o_busy,
   input wire logic o_done,
   input wire bcs_pkg::bcs_ans_t o_ans
);
   import bcs_pkg::*;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   // A request counts only while idle, so refused ones never start a check.
   wire logic tk = i_valid && !o_busy && i_req.op != BCS_OP_NONE;
   wire logic [15:0] rel = i_req.pc + {{4{i_req.offset[11]}}, i_req.offset} + 16'h0001;
   sequence s_two;
      o_busy ##1 o_done;
   endsequence
   sequence s_three;
      o_busy[*2] ##1 o_done;
   endsequence
   AST_PJMP: assert property (tk && i_req.op == BCS_OP_POINTER_JUMP |=> s_two ##0
      (o_ans.pc == $past(i_z_pointer, 2) && o_ans.status == $past(i_status, 2)))
      else $error("pointer jump wrong");
   AST_OCALL: assert property (tk && i_req.op == BCS_OP_OFFSET_CALL |=> s_three ##0
      (o_ans.pc == $past(rel, 3) && o_ans.push)) else $error("offset call wrong");
   AST_PCALL: assert property (tk && i_req.op == BCS_OP_POINTER_CALL |=> s_three ##0
      (o_ans.pc == $past(i_z_pointer, 3) && o_ans.push)) else $error("pointer call wrong");
   AST_DCALL: assert property (tk && i_req.op == BCS_OP_DIRECT_CALL |=> o_busy[*3] ##1
      (o_done && o_ans.pc == $past(i_req.target, 4) && o_ans.push))
      else $error("direct call wrong");
   AST_CMPI: assert property (tk && i_req.op == BCS_OP_COMPARE_IMMEDIATE |=> o_done &&
      o_ans.status[1] == ($past(i_req.opnd_a) == $past(i_req.opnd_b)) &&
      o_ans.status[0] == ($past(i_req.opnd_a) < $past(i_req.opnd_b)))
      else $error("compare flags wrong");
   AST_SKIP2: assert property (tk && i_req.op == BCS_OP_SKIP_REG_BIT_SET &&
      i_req.opnd_a[i_req.bit_sel] && i_req.next_two_words |=> s_three ##0
      o_ans.pc == $past(i_req.pc, 3) + 16'h0003) else $error("two word skip wrong");
   AST_BRANCH_SIGNED_LT: assert property (tk && i_req.op == BCS_OP_BRANCH_SIGNED_LT &&
      (i_status[2] ^ i_status[3]) |=> s_two ##0 o_ans.pc == $past(rel, 2))
      else $error("taken branch wrong");
   AST_BRANCH_CARRY_CLEAR: assert property (tk && i_req.op == BCS_OP_BRANCH_CARRY_CLEAR &&
      i_status[0] |=> o_done && o_ans.pc == $past(i_req.pc) + 16'h0001 &&
      o_ans.status == $past(i_status)) else $error("untaken branch wrong");
endmodule : bcs_unit_sva
bind bcs_unit bcs_unit_sva i_chk (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_valid(i_valid),
   .i_req(i_req), .i_z_pointer(i_z_pointer), .i_status(i_status), .o_busy(o_busy),
   .o_done(o_done), .o_ans(o_ans));
`default_nettype wire

// file: tb/bcs_fetch_model.sv
// Fetch side model: follows the PC that each finished operation hands back.
`timescale 1ns/1ps
`default_nettype none
module bcs_fetch_model (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_done,
   input wire bcs_pkg::bcs_ans_t i_ans,
   output logic [15:0] o_fetch_pc
);
   import bcs_pkg::*;
   // Fetch moves only on a finished result, so a stale answer is never refetched.
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_fetch_pc <= 16'h0000;
      end else if (i_done) begin
         o_fetch_pc <= i_ans.pc;
      end
   end
endmodule : bcs_fetch_model
`default_nettype wire

// file: tb/test_bcs_unit.sv
// Self-checking testbench for the branch, compare and skip unit.
`timescale 1ns/1ps
`default_nettype none
module test_bcs_unit;
   import bcs_pkg::*;
   logic i_clock = 1'b0;
   logic i_reset_n = 1'b0;
   logic i_valid = 1'b0;
   bcs_req_t i_req = '0;
   logic [15:0] i_z_pointer = 16'h0000;
   logic [7:0] i_status = 8'h00;
   logic o_busy;
   logic o_done;
   bcs_ans_t o_ans;
   logic [15:0] fpc;
   bcs_ans_t exp_q[$];
   int error_cnt = 0;
   int tests_run = 0;
   // Half period of 2.5 ns gives 200 MHz.
   always #2.5 i_clock = ~i_clock;
   bcs_unit i_dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_valid(i_valid), .i_req(i_req),
      .i_z_pointer(i_z_pointer), .i_status(i_status), .o_busy(o_busy), .o_done(o_done),
      .o_ans(o_ans));
   bcs_fetch_model i_fetch (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_done(o_done),
      .i_ans(o_ans), .o_fetch_pc(fpc));
   task automatic check(input logic [40:0] seen, input logic [40:0] want);
      tests_run++;
      if (seen !== want) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   // Reference result worked out from the operation, the operands and the flags.
   function automatic bcs_ans_t model(input bcs_req_t r, input logic [15:0] z, input logic [7:0] s);
      bcs_ans_t a;
      logic t;
      logic v;
      logic [7:0] x;
      logic [7:0] y;
      logic [7:0] d;
      logic [15:0] rel;
      x = r.opnd_a;
      y = r.opnd_b;
      d = x - y;
      rel = r.pc + {{4{r.offset[11]}}, r.offset} + 16'h0001;
      a = '{pc: r.pc + 16'h0001, push: 1'b0, ret_addr: r.pc + 16'h0001, status: s};
      case (r.op)
         BCS_OP_COMPARE_SKIP_EQUAL: t = x == y;
         BCS_OP_SKIP_REG_BIT_CLEAR, BCS_OP_SKIP_IO_BIT_CLEAR: t = !x[r.bit_sel];
         BCS_OP_SKIP_REG_BIT_SET, BCS_OP_SKIP_IO_BIT_SET: t = x[r.bit_sel];
         BCS_OP_BRANCH_FLAG_SET: t = s[r.bit_sel];
         BCS_OP_BRANCH_FLAG_CLEAR: t = !s[r.bit_sel];
         BCS_OP_BRANCH_CARRY_CLEAR, BCS_OP_BRANCH_UNSIGNED_GE: t = !s[0];
         BCS_OP_BRANCH_SIGNED_GE: t = !(s[2] ^ s[3]);
         BCS_OP_BRANCH_SIGNED_LT: t = s[2] ^ s[3];
         BCS_OP_BRANCH_OVERFLOW_SET: t = s[3];
         default: t = 1'b0;
      endcase
      if (t && r.op >= BCS_OP_BRANCH_FLAG_SET) a.pc = rel;
      else if (t) a.pc = r.pc + (r.next_two_words ? 16'h0003 : 16'h0002);
      if (r.op inside {BCS_OP_POINTER_JUMP, BCS_OP_POINTER_CALL}) a.pc = z;
      if (r.op == BCS_OP_OFFSET_CALL) a.pc = rel;
      if (r.op == BCS_OP_DIRECT_CALL) a.pc = r.target;
      if (r.op == BCS_OP_DIRECT_CALL) a.ret_addr = r.pc + 16'h0002;
      a.push = r.op inside {BCS_OP_OFFSET_CALL, BCS_OP_POINTER_CALL, BCS_OP_DIRECT_CALL};
      v = (x[7] & !y[7] & !d[7]) | (!x[7] & y[7] & d[7]);
      // Flag order from the top: H, S, V, N, Z, C.
      if (r.op == BCS_OP_COMPARE_IMMEDIATE) a.status[5:0] = {(!x[3] & y[3]) | (y[3] & d[3]) |
         (d[3] & !x[3]), d[7] ^ v, v, d[7], d == 8'h00, x < y};
      return a;
   endfunction : model
   // Notes the result of one request, drives it, then waits a bounded time for the answer.
   task automatic issue(input bcs_req_t r, input logic [15:0] z, input logic [7:0] s);
      bcs_ans_t w;
      int k;
      w = model(r, z, s);
      exp_q.push_back(w);
      @(posedge i_clock);
      i_valid <= 1'b1;
      i_req <= r;
      i_z_pointer <= z;
      i_status <= s;
      @(posedge i_clock);
      i_valid <= 1'b0;
      for (k = 0; k < 8 && exp_q.size() > 0; k++) @(posedge i_clock);
      #1;
      // A missing answer is a mismatch in its own right.
      if (exp_q.size() > 0) begin
         error_cnt++;
         $display("[FAIL] t=%0t no answer within the wait limit", $time);
         give_verdict();
      end
      check({25'h0, fpc}, {25'h0, w.pc});
   endtask : issue
   // Every answer is matched against the oldest note.
   always @(posedge i_clock) begin
      if (o_done === 1'b1) begin
         check(o_ans, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
      end
   end
   initial begin
      bcs_req_t r;
      logic [95:0] rv;
      int n;
      void'($urandom(32'h0dfce8a9));
      repeat (2) @(posedge i_clock);
      i_reset_n <= 1'b1;
      for (n = 0; n < 340; n++) begin
         rv = {$urandom, $urandom, $urandom};
         r = rv[$bits(r)-1:0];
         r.op = bcs_op_t'(n % 17 + 1);
         r.offset = {{5{r.offset[6]}}, r.offset[6:0]};
         if (n[0]) r.opnd_b = r.opnd_a;
         issue(r, rv[15:0], rv[23:16]);
      end
      $display("sweep of all operations done");
      give_verdict();
   end
endmodule : test_bcs_unit
`default_nettype wire
